// *** clk_select.sv ***
/*
 * system clock source selector: two internal oscillators, a peripheral
 * rc oscillator, an external logic-level clock, run-time switching
 * without runt pulses, and the second oscillator pin as gpio or clock out.
 * assumes all inputs synchronous to CLK and configuration pins that hold
 * still while RESET is high.
 */
// The implementer's own choices: the address map and strobed register access.
// How it works
// - a 16 MHz fast and a 31 kHz slow internal oscillator can drive the system clock.
// - a 600 kHz rc oscillator gives a separate peripheral clock.
// - a two-bit select field in the control register picks the system clock source.
// - the configuration oscillator field sets the default source after any reset.
// - a run-time write switches to the secondary oscillator, the fast internal one or back to the configured source.
// - in external mode the clock on the first oscillator pin is used directly.
// - in external mode the second oscillator pin is gpio or a clock output.
// - external mode has high, medium and low power settings chosen by configuration.
`include "clk_select_params.svh"
`default_nettype none
module clk_select
	import clk_select_pkg::*;
#(
	parameter int NCO_W = `NCO_W,
	parameter int SETTLE = `SETTLE_EDGES
) (
	input wire logic CLK, // 50 MHz clock
	input wire logic RESET, // synchronous, active high
	input wire reg_req_t REG_REQ, // register bus request
	output logic [7:0] RDATA, // read data, cycle after read
	input wire cfg_word_t CFG, // configuration word pins
	input wire logic OSC_IN_PIN, // external clock input
	input wire logic OSC_OUT_PIN_IN, // second pin, input level
	output logic OSC_OUT_PIN_OUT, // second pin, output level
	output logic OSC_OUT_PIN_OE, // second pin, drive enable
	output logic SYS_CLK_OUT, // selected system clock
	output logic PERIPH_CLK, // peripheral rc clock
	output pwr_t EXT_POWER, // external mode power setting
	output logic SWITCH_BUSY // source switch in progress
);

	localparam logic [NCO_W-1:0] INCS [3] = '{
		NCO_W'(`NCO_INC(`FAST_OSC_HZ)),
		NCO_W'(`NCO_INC(`SLOW_OSC_HZ)),
		NCO_W'(`NCO_INC(`RC_OSC_HZ))
	};

	generate
		if (SETTLE < 1 || SETTLE > 15) begin : g_bad
			$error("clk_select: SETTLE must be 1..15");
		end
	endgenerate

	logic [2:0] lvl; // 0 fast, 1 slow, 2 rc
	logic [1:0] sel_q;
	src_t active_q, tgt;
	cfg_word_t cfg_q;
	sw_state_t state_q;
	logic [3:0] edges_q;
	logic prev_q, cur_lvl, sys_clk_d;
	logic gpio_out_q, gpio_oe_q, ext_mode;

	// internal oscillators, one accumulator each
	generate
		for (genvar i = 0; i < 3; i++) begin : g_osc
			osc_nco #(.W(NCO_W), .INC(INCS[i])) u_osc (
				.clk(CLK),
				.reset(RESET),
				.level(lvl[i])
			);
		end
	endgenerate

	function automatic logic src_level(input src_t s, input logic [2:0] l, input logic ext);
		unique case (s)
			SRC_EXT: src_level = ext; // pin used as is
			SRC_SLOW: src_level = l[1];
			SRC_FAST: src_level = l[0];
			default: src_level = 1'b0;
		endcase
	endfunction

	function automatic src_t cfg_src(input logic [1:0] osc_sel);
		cfg_src = (osc_sel == `CFG_INTOSC) ? SRC_FAST : SRC_EXT;
	endfunction

	// select decode: 00 configured source, 01 secondary, 1x fast
	always_comb begin
		unique case (sel_q)
			2'h0: tgt = cfg_src(cfg_q.osc_sel);
			2'h1: tgt = SRC_SLOW;
			default: tgt = SRC_FAST;
		endcase
	end

	assign cur_lvl = src_level(active_q, lvl, OSC_IN_PIN);
	assign ext_mode = (active_q == SRC_EXT);

	// configuration is sampled during reset, as non-volatile bits would be
	always_ff @(posedge CLK) begin
		if (RESET) begin
			cfg_q <= CFG;
		end
	end

	// software select field
	always_ff @(posedge CLK) begin
		if (RESET) begin
			sel_q <= `SEL_RST;
		end else if (REG_REQ.wr && REG_REQ.addr == `OCR_ADDR) begin
			sel_q <= REG_REQ.wdata[`SEL_LSB +: 2];
		end
	end

	// gpio side of the second pin
	always_ff @(posedge CLK) begin
		if (RESET) begin
			gpio_out_q <= 1'b0;
			gpio_oe_q <= 1'b0;
		end else if (REG_REQ.wr && REG_REQ.addr == `PIN_ADDR) begin
			gpio_out_q <= REG_REQ.wdata[`PIN_OUT_BIT];
			gpio_oe_q <= REG_REQ.wdata[`PIN_OE_BIT];
		end
	end

	// switch sequencer: drain the old source to low, then hold low while
	// the new source gives SETTLE rising edges, so no short pulse escapes
	always_ff @(posedge CLK) begin
		if (RESET) begin
			state_q <= ST_RUN;
			active_q <= cfg_src(CFG.osc_sel);
			edges_q <= '0;
			prev_q <= 1'b0;
		end else begin
			prev_q <= cur_lvl;
			unique case (state_q)
				ST_RUN: begin
					if (tgt != active_q) begin
						state_q <= ST_DRAIN;
					end
				end
				ST_DRAIN: begin
					if (!cur_lvl) begin
						state_q <= ST_HOLD;
						active_q <= tgt;
						edges_q <= '0;
					end
				end
				ST_HOLD: begin
					if (cur_lvl && !prev_q && edges_q < 4'(SETTLE)) begin
						edges_q <= edges_q + 4'h1;
					end else if (edges_q == 4'(SETTLE) && !cur_lvl) begin
						state_q <= ST_RUN;
					end
				end
			endcase
		end
	end

	// output is held low in hold so the first new high phase is whole
	assign sys_clk_d = (state_q == ST_HOLD) ? 1'b0 : cur_lvl;

	// clock and status outputs
	always_ff @(posedge CLK) begin
		if (RESET) begin
			SYS_CLK_OUT <= 1'b0;
			PERIPH_CLK <= 1'b0;
			EXT_POWER <= PWR_OFF;
			SWITCH_BUSY <= 1'b0;
		end else begin
			SYS_CLK_OUT <= sys_clk_d;
			PERIPH_CLK <= lvl[2];
			EXT_POWER <= ext_mode ? pwr_t'(cfg_q.osc_sel) : PWR_OFF;
			SWITCH_BUSY <= (state_q != ST_RUN);
		end
	end

	// second pin: clock out when enabled in external mode, else gpio
	always_ff @(posedge CLK) begin
		if (RESET) begin
			OSC_OUT_PIN_OUT <= 1'b0;
			OSC_OUT_PIN_OE <= 1'b0;
		end else if (ext_mode && cfg_q.clock_output_en) begin
			OSC_OUT_PIN_OUT <= sys_clk_d;
			OSC_OUT_PIN_OE <= 1'b1;
		end else begin
			OSC_OUT_PIN_OUT <= gpio_out_q;
			OSC_OUT_PIN_OE <= gpio_oe_q;
		end
	end

	// read port; unmapped offsets read zero
	always_ff @(posedge CLK) begin
		if (RESET) begin
			RDATA <= 8'h00;
		end else if (REG_REQ.rd) begin
			RDATA <= 8'h00;
			unique case (REG_REQ.addr)
				`OCR_ADDR: RDATA[`SEL_LSB +: 2] <= sel_q;
				`STAT_ADDR: begin
					RDATA[`STAT_SRC_LSB +: 2] <= active_q;
					RDATA[`STAT_BUSY_BIT] <= (state_q != ST_RUN);
					RDATA[`STAT_EXT_BIT] <= ext_mode;
					RDATA[`STAT_PWR_LSB +: 2] <= cfg_q.osc_sel;
				end
				`PIN_ADDR: begin
					RDATA[`PIN_OUT_BIT] <= gpio_out_q;
					RDATA[`PIN_OE_BIT] <= gpio_oe_q;
					RDATA[`PIN_IN_BIT] <= OSC_OUT_PIN_IN;
				end
				default: RDATA <= 8'h00;
			endcase
		end else begin
			RDATA <= 8'h00;
		end
	end

	// checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);

	sequence s_sel_write;
		REG_REQ.wr && REG_REQ.addr == `OCR_ADDR;
	endsequence

	sequence s_drain_done;
		state_q == ST_DRAIN && !cur_lvl;
	endsequence

	AST_FAST_HIGH_SHORT: assert property (lvl[0] && $past(lvl[0]) |=> !lvl[0])
		else $error("fast oscillator high too long");
	AST_SLOW_HIGH_LONG: assert property ($rose(lvl[1]) |-> lvl[1] [*8])
		else $error("slow oscillator high phase too short");
	AST_PERIPH_FOLLOWS: assert property ($rose(lvl[2]) |=> PERIPH_CLK [*8])
		else $error("peripheral clock does not follow rc oscillator");
	AST_SEL_STORE: assert property (s_sel_write |=> sel_q == $past(REG_REQ.wdata[1:0]))
		else $error("select field not stored");
	AST_RESET_DEFAULT: assert property ($fell(RESET) |-> active_q == cfg_src(cfg_q.osc_sel))
		else $error("default source does not match configuration");
	AST_SWITCH_STARTS: assert property (state_q == ST_RUN && tgt != active_q
		|=> state_q == ST_DRAIN ##1 SWITCH_BUSY)
		else $error("switch not started on new select");
	AST_EXT_DIRECT: assert property (state_q != ST_HOLD && ext_mode
		|=> SYS_CLK_OUT == $past(OSC_IN_PIN))
		else $error("external clock not passed through");
	AST_PIN_GPIO: assert property (ext_mode && !cfg_q.clock_output_en
		|=> OSC_OUT_PIN_OE == $past(gpio_oe_q) && OSC_OUT_PIN_OUT == $past(gpio_out_q))
		else $error("second pin not under gpio control");
	AST_EXT_POWER: assert property (ext_mode |=> EXT_POWER == pwr_t'($past(cfg_q.osc_sel)))
		else $error("power setting does not follow configuration");
	AST_HOLD_LOW: assert property (s_drain_done |=> !SYS_CLK_OUT ##1 !SYS_CLK_OUT)
		else $error("system clock not held low after drain");

endmodule
`default_nettype wire

// *** clk_select_params.svh ***
/*
 * constants of the system clock selector: bus offsets, field positions,
 * reset values, oscillator rates and oscillator step sizes.
 * assumes a 50 MHz CLK and inclusion by its bare name.
 */
`ifndef CLK_SELECT_PARAMS_SVH
`define CLK_SELECT_PARAMS_SVH

// timing base
`define CLK_HZ 64'd50000000
`define FAST_OSC_HZ 64'd16000000
`define SLOW_OSC_HZ 64'd31000
`define RC_OSC_HZ 64'd600000
`define NCO_W 24
// step per CLK of a phase accumulator running at hz
`define NCO_INC(hz) (((hz) << `NCO_W) / `CLK_HZ)

// external clock power ranges, top of each range in Hz
`define EXT_HI_MAX_HZ 64'd20000000
`define EXT_MID_MAX_HZ 64'd4000000
`define EXT_LO_MAX_HZ 64'd500000

// register offsets
`define OCR_ADDR 4'h0
`define STAT_ADDR 4'h1
`define PIN_ADDR 4'h2

// oscillator_control_reg fields
`define SEL_LSB 0
`define SEL_RST 2'h0
// status fields
`define STAT_SRC_LSB 0
`define STAT_BUSY_BIT 2
`define STAT_EXT_BIT 3
`define STAT_PWR_LSB 4
// pin control fields
`define PIN_OUT_BIT 0
`define PIN_OE_BIT 1
`define PIN_IN_BIT 2

// configuration oscillator field codes
`define CFG_INTOSC 2'h0
`define CFG_EXT_LOW 2'h1
`define CFG_EXT_MID 2'h2
`define CFG_EXT_HIGH 2'h3

// rising edges of the new source waited for after a switch
`define SETTLE_EDGES 2

`endif

// *** clk_select_pkg.sv ***
/*
 * types of the system clock selector: bus request, configuration word,
 * source codes, power settings and switch states.
 * assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package clk_select_pkg;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic [1:0] osc_sel;
		logic clock_output_en;
	} cfg_word_t;

	typedef enum logic [1:0] {
		SRC_EXT = 2'h0,
		SRC_SLOW = 2'h1,
		SRC_FAST = 2'h2
	} src_t;

	typedef enum logic [1:0] {
		PWR_OFF = 2'h0,
		PWR_LOW = 2'h1,
		PWR_MED = 2'h2,
		PWR_HIGH = 2'h3
	} pwr_t;

	typedef enum logic [2:0] {
		ST_RUN = 3'b001,
		ST_DRAIN = 3'b010,
		ST_HOLD = 3'b100
	} sw_state_t;

endpackage
`default_nettype wire

// *** osc_nco.sv ***
/*
 * one oscillator modelled as a phase accumulator on CLK; the top bit is
 * the square-wave level of the oscillator.
 * assumes a free-running CLK and a synchronous active-high reset.
 */
`default_nettype none
module osc_nco #(
	parameter int W = 24,
	parameter logic [W-1:0] INC = '0
) (
	input wire logic clk, // system clock
	input wire logic reset, // synchronous reset
	output logic level // oscillator level
);

	logic [W-1:0] acc_q;

	generate
		if (W < 8 || INC == '0) begin : g_bad
			$error("osc_nco: width too small or zero step");
		end
	endgenerate

	// accumulate; truncation of the step keeps the rate within one lsb
	always_ff @(posedge clk) begin
		if (reset) begin
			acc_q <= '0;
		end else begin
			acc_q <= acc_q + INC;
		end
	end

	assign level = acc_q[W-1];

endmodule
`default_nettype wire

// *** ext_osc_model.sv ***
/*
 * external logic-level oscillator that drives the first oscillator pin.
 * assumes the bench clock; half period given in CLK cycles.
 */
`default_nettype none
module ext_osc_model #(
	parameter int HALF = 5
) (
	input wire logic CLK, // bench clock
	input wire logic run, // oscillator powered
	output logic osc_out // level onto the pin
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0;
	initial osc_out = 1'b0;
	// square wave; parks low when unpowered so no stale level looks like a clock
	always @(posedge CLK) begin
		if (!run) begin
			osc_out <= 1'b0;
			cnt = 0;
		end else if (cnt == HALF - 1) begin
			osc_out <= ~osc_out;
			cnt = 0;
		end else begin
			cnt = cnt + 1;
		end
	end
endmodule
`default_nettype wire

// *** system_clock_source_select_tb_top.sv ***
/*
 * self-checking bench of the system clock selector.
 * assumes the selector's hand-over timing and a 5 MHz external clock.
 */
`default_nettype none
module system_clock_source_select_tb_top
	import clk_select_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic CLK = 1'b0, RESET = 1'b1, drv = 1'b0, run = 1'b0;
	reg_req_t req = '0;
	cfg_word_t cfg = '0;
	logic [7:0] rdata, v;
	logic pin_in, pin_out, pin_oe, sys_clk, per_clk, busy, lvl;
	pwr_t pwr;
	int errors = 0, samples_checked = 0, n;
	// second pin wire: the selector wins while it drives
	assign lvl = pin_oe ? pin_out : drv;
	ext_osc_model #(.HALF(5)) osc (.CLK(CLK), .run(run), .osc_out(pin_in));
	clk_select uut (.CLK(CLK), .RESET(RESET), .REG_REQ(req), .RDATA(rdata), .CFG(cfg),
		.OSC_IN_PIN(pin_in), .OSC_OUT_PIN_IN(lvl), .OSC_OUT_PIN_OUT(pin_out),
		.OSC_OUT_PIN_OE(pin_oe), .SYS_CLK_OUT(sys_clk), .PERIPH_CLK(per_clk),
		.EXT_POWER(pwr), .SWITCH_BUSY(busy));
	// 50 MHz clock
	initial forever #10 CLK = ~CLK;
	task automatic check8(string what, logic [7:0] exp, logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic check_rng(string what, int lo, int hi, int got);
		samples_checked++;
		if (got < lo || got > hi) begin
			errors++;
			$display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask
	task automatic wr(logic [3:0] a, logic [7:0] d);
		@(posedge CLK);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge CLK);
		req.wr <= 1'b0;
	endtask
	task automatic rd(logic [3:0] a, output logic [7:0] d);
		@(posedge CLK);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge CLK);
		req.rd <= 1'b0;
		#1 d = rdata;
	endtask
	// configuration pins only move under reset
	task automatic do_reset(logic [1:0] sel, logic co);
		@(posedge CLK);
		cfg <= '{osc_sel: sel, clock_output_en: co};
		RESET <= 1'b1;
		run <= (sel != 2'h0);
		repeat (5) @(posedge CLK);
		RESET <= 1'b0;
	endtask
	// bounded wait on the switch flag
	task automatic wait_busy(logic l, int lim, output int c);
		c = 0;
		#1;
		while (busy !== l && c < lim) begin
			@(posedge CLK);
			#1 c++;
		end
	endtask
	task automatic switch_to(logic [7:0] s, logic [7:0] src);
		wr(4'h0, s);
		wait_busy(1'b1, 8, n);
		check_rng("busy rise", 1, 2, n);
		wait_busy(1'b0, 5000, n);
		check_rng("busy fall", 1, 4999, n);
		rd(4'h1, v);
		check8("active src", src, v & 8'h07);
	endtask
	task automatic rises(bit per, int cyc, output int c);
		logic p;
		c = 0;
		p = per ? per_clk : sys_clk;
		repeat (cyc) begin
			@(posedge CLK);
			#1 if (!p && (per ? per_clk : sys_clk)) c++;
			p = per ? per_clk : sys_clk;
		end
	endtask
	task automatic t_default();
		do_reset(2'h0, 1'b0);
		rd(4'h1, v);
		check8("status", 8'h02, v);
		check8("power", 8'h00, {6'h0, pwr});
		wr(4'h1, 8'hff);
		rd(4'h1, v);
		check8("status ro", 8'h02, v);
		rd(4'hf, v);
		check8("unmapped", 8'h00, v);
		rises(1'b0, 1000, n);
		check_rng("fast rises", 318, 322, n);
		rises(1'b1, 5000, n);
		check_rng("rc rises", 59, 61, n);
	endtask
	// every external power code, clock output on
	task automatic t_ext();
		logic p;
		for (int c = 1; c < 4; c++) begin
			do_reset(c[1:0], 1'b1);
			rd(4'h1, v);
			check8("ext status", {2'h0, c[1:0], 4'h8}, v);
			check8("power", c[7:0], {6'h0, pwr});
			repeat (40) begin
				p = pin_in;
				@(posedge CLK);
				#1 check8("sys clk", {7'h0, p}, {7'h0, sys_clk});
				check8("clock_output oe", 8'h01, {7'h0, pin_oe});
				check8("clock_output", {7'h0, sys_clk}, {7'h0, pin_out});
			end
		end
	endtask
	task automatic t_gpio();
		do_reset(2'h3, 1'b0);
		drv <= 1'b1;
		wr(4'h2, 8'h02);
		repeat (2) @(posedge CLK);
		#1 check8("gpio pins", 8'h02, {6'h0, pin_oe, pin_out});
		rd(4'h2, v);
		check8("gpio rd", 8'h02, v & 8'h07);
		wr(4'h2, 8'h00);
		rd(4'h2, v);
		check8("gpio in", 8'h04, v & 8'h07);
	endtask
	task automatic t_switch();
		do_reset(2'h2, 1'b0);
		switch_to(8'h01, 8'h01);
		wait_busy(1'b1, 0, n);
		n = 0;
		while (sys_clk !== 1'b1 && n < 2000) begin
			@(posedge CLK);
			#1 n++;
		end
		n = 0;
		while (sys_clk === 1'b1 && n < 2000) begin
			@(posedge CLK);
			#1 n++;
		end
		check_rng("first slow high", 800, 812, n);
		switch_to(8'h00, 8'h00);
		do_reset(2'h0, 1'b0);
		switch_to(8'h01, 8'h01);
		switch_to(8'h02, 8'h02);
	endtask
	task automatic summarize();
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (5) @(posedge CLK);
		RESET <= 1'b0;
		t_default();
		t_ext();
		t_gpio();
		t_switch();
		summarize();
	end
	// watchdog, well past the roughly 14000 cycles the tests need
	initial begin
		repeat (100000) @(posedge CLK);
		errors++;
		summarize();
	end
endmodule
`default_nettype wire
